// file: rtl/audio_mixer_volume_regs.sv
/*
 mixer volume and mute register bank with its capability register.
 assumes one clock (clk), synchronous active-high link reset (rst), and a master
 that never strobes read and write together.
*/
`timescale 1ns/100ps

// Contract
// RQ1: reset register write restores all mixer defaults
// RQ2: capability reads 20-bit ADC and DAC
// RQ3: capability bit 4 reports alternate line out
// RQ4: enhancement code field fixed, read only
// RQ5: line level select must be set first
// RQ6: bit 15 mutes each path
// RQ7: master left/right five-bit attenuation, 1.5 dB steps
// RQ8: alternate line uses master attenuation layout
// RQ9: mono holds five-bit attenuation in bits 4:0
// RQ10: beep four-bit attenuation bits 4:1, 3 dB
// RQ11: beep passes to line outs during reset
// RQ12: phone five-bit gain, 32 levels
// RQ13: mic bit 6 adds 20 dB boost
// RQ14: mic five-bit gain on input scale
// RQ15: line input independent left/right gains
// RQ16: cd input independent left/right gains
// RQ17: output and beep registers reset 8000
// RQ18: phone and mic registers reset 8008
// RQ19: line, cd, video reset 8808
// RQ20: reserved, unimplemented, odd indexes read zero
// RQ21: input gain code 8 is 0 dB
// RQ22: read-only and reserved bits ignore writes
module audio_mixer_volume_regs #(
	parameter logic [4:0] ENH_CODE = mixer_regs_pkg::ENH_CODE_DEFAULT
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [6:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic             master_mute,
	output logic      [4:0]  master_left_out_atten,
	output logic      [4:0]  master_right_out_atten,
	output logic             alt_mute,
	output logic      [4:0]  alt_left_out_atten,
	output logic      [4:0]  alt_right_out_atten,
	output logic             line_level_select,
	output logic             mono_mute,
	output logic      [4:0]  mono_out_atten,
	output logic             beep_mute,
	output logic      [3:0]  beep_atten,
	output logic             beep_input_bypass,
	output logic             phone_mute,
	output logic      [4:0]  phone_single_input_gain,
	output logic             mic_mute,
	output logic      [4:0]  mic_single_input_gain,
	output logic             mic_boost_enable,
	output logic             line_mute,
	output logic      [4:0]  line_left_input_gain,
	output logic      [4:0]  line_right_input_gain,
	output logic             cd_mute,
	output logic      [4:0]  cd_left_input_gain,
	output logic      [4:0]  cd_right_input_gain,
	output logic             video_mute,
	output logic      [4:0]  video_left_input_gain,
	output logic      [4:0]  video_right_input_gain
);

	localparam int NV = mixer_regs_pkg::NUM_VOL;

	logic        mixer_default;
	logic [15:0] vol_q [NV];
	logic        lvl_q;
	logic        bypass_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic [15:0] cap_word;

	// any data written to index zero reloads defaults
	assign mixer_default = wr && (addr == mixer_regs_pkg::IDX_RESET); // RQ1

	for (genvar i = 0; i < NV; i++) begin : g_vol
		always_ff @(posedge clk) begin
			if (rst || mixer_default) begin
				vol_q[i] <= mixer_regs_pkg::VOL_RESET[i]; // RQ1 RQ17 RQ18 RQ19
			end else if (wr && addr == mixer_regs_pkg::VOL_INDEX[i]) begin
				vol_q[i] <= wdata & mixer_regs_pkg::VOL_MASK[i]; // RQ22
			end
		end
	end

	// line-level select lives in the test control word, not a mixer register
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_q <= mixer_regs_pkg::RST_LVL;
		end else if (wr && addr == mixer_regs_pkg::IDX_TEST_CTRL) begin
			lvl_q <= wdata[mixer_regs_pkg::LVL_BIT]; // RQ5
		end
	end

	// analog bypass of the beep pin, following link reset one clock later on set and on release
	always_ff @(posedge clk) begin
		bypass_q <= rst; // RQ11
	end

	always_comb begin
		cap_word = '0;
		cap_word[mixer_regs_pkg::ENH_LSB +: 5] = ENH_CODE; // RQ4
		cap_word[mixer_regs_pkg::ADC20_BIT]    = 1'b1; // RQ2
		cap_word[mixer_regs_pkg::DAC20_BIT]    = 1'b1; // RQ2
		cap_word[mixer_regs_pkg::ALT_LINE_BIT] = 1'b1; // RQ3
	end

	always_comb begin
		rdata_d = '0; // RQ20
		if (addr == mixer_regs_pkg::IDX_RESET) begin
			rdata_d = cap_word; // RQ22
		end
		if (addr == mixer_regs_pkg::IDX_TEST_CTRL) begin
			rdata_d[mixer_regs_pkg::LVL_BIT] = lvl_q;
		end
		for (int i = 0; i < NV; i++) begin
			if (addr == mixer_regs_pkg::VOL_INDEX[i]) begin
				rdata_d = vol_q[i];
			end
		end
	end

	// read data stand only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign rdata = rdata_q;

	// field taps, every one straight off a register bit
	assign master_mute            = vol_q[mixer_regs_pkg::SLOT_MASTER][15]; // RQ6
	assign master_left_out_atten  = vol_q[mixer_regs_pkg::SLOT_MASTER][12:8]; // RQ7
	assign master_right_out_atten = vol_q[mixer_regs_pkg::SLOT_MASTER][4:0]; // RQ7
	assign alt_mute               = vol_q[mixer_regs_pkg::SLOT_ALT][15]; // RQ6
	assign alt_left_out_atten     = vol_q[mixer_regs_pkg::SLOT_ALT][12:8]; // RQ8
	assign alt_right_out_atten    = vol_q[mixer_regs_pkg::SLOT_ALT][4:0]; // RQ8
	assign line_level_select      = lvl_q; // RQ5
	assign mono_mute              = vol_q[mixer_regs_pkg::SLOT_MONO][15]; // RQ6
	assign mono_out_atten         = vol_q[mixer_regs_pkg::SLOT_MONO][4:0]; // RQ9
	assign beep_mute              = vol_q[mixer_regs_pkg::SLOT_BEEP][15]; // RQ6
	assign beep_atten             = vol_q[mixer_regs_pkg::SLOT_BEEP][4:1]; // RQ10
	assign beep_input_bypass      = bypass_q; // RQ11
	assign phone_mute             = vol_q[mixer_regs_pkg::SLOT_PHONE][15]; // RQ6
	assign phone_single_input_gain = vol_q[mixer_regs_pkg::SLOT_PHONE][4:0]; // RQ12 RQ21
	assign mic_mute               = vol_q[mixer_regs_pkg::SLOT_MIC][15]; // RQ6
	assign mic_single_input_gain  = vol_q[mixer_regs_pkg::SLOT_MIC][4:0]; // RQ14 RQ21
	assign mic_boost_enable       = vol_q[mixer_regs_pkg::SLOT_MIC][6]; // RQ13
	assign line_mute              = vol_q[mixer_regs_pkg::SLOT_LINE][15]; // RQ6
	assign line_left_input_gain   = vol_q[mixer_regs_pkg::SLOT_LINE][12:8]; // RQ15
	assign line_right_input_gain  = vol_q[mixer_regs_pkg::SLOT_LINE][4:0]; // RQ15
	assign cd_mute                = vol_q[mixer_regs_pkg::SLOT_CD][15]; // RQ6
	assign cd_left_input_gain     = vol_q[mixer_regs_pkg::SLOT_CD][12:8]; // RQ16
	assign cd_right_input_gain    = vol_q[mixer_regs_pkg::SLOT_CD][4:0]; // RQ16
	assign video_mute             = vol_q[mixer_regs_pkg::SLOT_VIDEO][15]; // RQ6
	assign video_left_input_gain  = vol_q[mixer_regs_pkg::SLOT_VIDEO][12:8];
	assign video_right_input_gain = vol_q[mixer_regs_pkg::SLOT_VIDEO][4:0];

	// checks
	sequence s_reset_write;
		wr && addr == mixer_regs_pkg::IDX_RESET;
	endsequence

	sequence s_reset_read;
		rd && addr == mixer_regs_pkg::IDX_RESET;
	endsequence

	sequence s_alt_write;
		wr && addr == mixer_regs_pkg::IDX_ALT_LINE;
	endsequence

	sequence s_mono_write;
		wr && addr == mixer_regs_pkg::IDX_MONO;
	endsequence

	sequence s_beep_write;
		wr && addr == mixer_regs_pkg::IDX_BEEP;
	endsequence

	sequence s_phone_write;
		wr && addr == mixer_regs_pkg::IDX_PHONE;
	endsequence

	sequence s_mic_write;
		wr && addr == mixer_regs_pkg::IDX_MIC;
	endsequence

	sequence s_line_write;
		wr && addr == mixer_regs_pkg::IDX_LINE_IN;
	endsequence

	sequence s_cd_write;
		wr && addr == mixer_regs_pkg::IDX_CD;
	endsequence

	sequence s_video_write;
		wr && addr == mixer_regs_pkg::IDX_VIDEO;
	endsequence

	sequence s_test_write;
		wr && addr == mixer_regs_pkg::IDX_TEST_CTRL;
	endsequence

	sequence s_test_read;
		rd && addr == mixer_regs_pkg::IDX_TEST_CTRL;
	endsequence

	// indexes past the last volume register, test control aside
	sequence s_unmapped_read;
		rd && addr > mixer_regs_pkg::IDX_VIDEO && addr != mixer_regs_pkg::IDX_TEST_CTRL;
	endsequence

	sequence s_odd_write;
		wr && addr[0];
	endsequence

	sequence s_stereo_read;
		rd && (addr == mixer_regs_pkg::IDX_MASTER || addr == mixer_regs_pkg::IDX_ALT_LINE
			|| addr == mixer_regs_pkg::IDX_LINE_IN || addr == mixer_regs_pkg::IDX_CD
			|| addr == mixer_regs_pkg::IDX_VIDEO);
	endsequence

	a_default_outputs: assert property (@(posedge clk) disable iff (rst) // RQ17
		s_reset_write |=> master_mute && master_left_out_atten == 5'h00 && alt_mute
			&& mono_mute && beep_mute && beep_atten == 4'h0)
		else $error("output registers not back to default");

	a_default_inputs: assert property (@(posedge clk) disable iff (rst) // RQ18
		s_reset_write |=> phone_mute && phone_single_input_gain == 5'h08
			&& mic_single_input_gain == 5'h08 && !mic_boost_enable)
		else $error("phone or mic not back to default");

	a_default_stereo_in: assert property (@(posedge clk) disable iff (rst) // RQ19
		s_reset_write |=> line_left_input_gain == 5'h08 && cd_right_input_gain == 5'h08
			&& video_mute && video_left_input_gain == 5'h08)
		else $error("stereo inputs not back to default");

	a_capability_read: assert property (@(posedge clk) disable iff (rst) // RQ2
		s_reset_read |=> rdata[8] && rdata[6] && rdata[4] && rdata[15] == 1'b0
			&& rdata[14:10] == ENH_CODE)
		else $error("capability word wrong");

	a_odd_index_zero: assert property (@(posedge clk) disable iff (rst) // RQ20
		rd && addr[0] |=> rdata == 16'h0000)
		else $error("odd index read not zero");

	a_master_write: assert property (@(posedge clk) disable iff (rst) // RQ7
		wr && addr == mixer_regs_pkg::IDX_MASTER |=> master_mute == $past(wdata[15])
			&& master_left_out_atten == $past(wdata[12:8])
			&& master_right_out_atten == $past(wdata[4:0]))
		else $error("master register did not take write");

	a_reserved_discard: assert property (@(posedge clk) disable iff (rst) // RQ22
		rd && addr == mixer_regs_pkg::IDX_MIC |=> rdata[14:7] == 8'h00 && rdata[5] == 1'b0)
		else $error("reserved mic bits stored");

	a_mic_boost: assert property (@(posedge clk) disable iff (rst) // RQ13
		wr && addr == mixer_regs_pkg::IDX_MIC |=> mic_boost_enable == $past(wdata[6]))
		else $error("mic boost not following write");

	a_beep_bypass: assert property (@(posedge clk) // RQ11
		rst [*2] |-> beep_input_bypass)
		else $error("beep bypass missing during reset");

	a_read_one_cycle: assert property (@(posedge clk) disable iff (rst)
		!rd |=> rdata == 16'h0000)
		else $error("read data held beyond one cycle");

	a_alt_write: assert property (@(posedge clk) disable iff (rst) // RQ8
		s_alt_write |=> alt_mute == $past(wdata[15])
			&& alt_left_out_atten == $past(wdata[12:8])
			&& alt_right_out_atten == $past(wdata[4:0]))
		else $error("alternate line register did not take write");

	a_mono_write: assert property (@(posedge clk) disable iff (rst) // RQ9
		s_mono_write |=> mono_mute == $past(wdata[15])
			&& mono_out_atten == $past(wdata[4:0]))
		else $error("mono register did not take write");

	a_beep_write: assert property (@(posedge clk) disable iff (rst) // RQ10
		s_beep_write |=> beep_mute == $past(wdata[15])
			&& beep_atten == $past(wdata[4:1]))
		else $error("beep register did not take write");

	a_phone_write: assert property (@(posedge clk) disable iff (rst) // RQ12
		s_phone_write |=> phone_mute == $past(wdata[15])
			&& phone_single_input_gain == $past(wdata[4:0]))
		else $error("phone register did not take write");

	a_mic_gain: assert property (@(posedge clk) disable iff (rst) // RQ14
		s_mic_write |=> mic_mute == $past(wdata[15])
			&& mic_single_input_gain == $past(wdata[4:0]))
		else $error("mic register did not take write");

	a_line_write: assert property (@(posedge clk) disable iff (rst) // RQ15
		s_line_write |=> line_mute == $past(wdata[15])
			&& line_left_input_gain == $past(wdata[12:8])
			&& line_right_input_gain == $past(wdata[4:0]))
		else $error("line input register did not take write");

	a_cd_write: assert property (@(posedge clk) disable iff (rst) // RQ16
		s_cd_write |=> cd_mute == $past(wdata[15])
			&& cd_left_input_gain == $past(wdata[12:8])
			&& cd_right_input_gain == $past(wdata[4:0]))
		else $error("cd input register did not take write");

	a_video_write: assert property (@(posedge clk) disable iff (rst) // RQ6
		s_video_write |=> video_mute == $past(wdata[15])
			&& video_left_input_gain == $past(wdata[12:8])
			&& video_right_input_gain == $past(wdata[4:0]))
		else $error("video input register did not take write");

	a_level_write: assert property (@(posedge clk) disable iff (rst) // RQ5
		s_test_write |=> line_level_select == $past(wdata[15]))
		else $error("line level select did not take write");

	a_level_kept: assert property (@(posedge clk) disable iff (rst) // RQ1
		s_reset_write |=> $stable(line_level_select))
		else $error("reset register write changed line level select");

	a_unmapped_zero: assert property (@(posedge clk) disable iff (rst) // RQ20
		s_unmapped_read |=> rdata == 16'h0000)
		else $error("unmapped index read not zero");

	a_test_read: assert property (@(posedge clk) disable iff (rst) // RQ5
		s_test_read |=> rdata[15] == line_level_select
			&& rdata[14:0] == 15'h0000)
		else $error("test control word read wrong");

	a_bypass_release: assert property (@(posedge clk) // RQ11
		!rst |=> !beep_input_bypass)
		else $error("beep bypass held after reset release");

	a_rst_outputs: assert property (@(posedge clk) // RQ17
		rst |=> master_mute && alt_mute && mono_mute && beep_mute
			&& master_left_out_atten == 5'h00 && master_right_out_atten == 5'h00
			&& alt_left_out_atten == 5'h00 && alt_right_out_atten == 5'h00
			&& mono_out_atten == 5'h00 && beep_atten == 4'h0)
		else $error("output registers not at default after reset");

	a_rst_inputs: assert property (@(posedge clk) // RQ18
		rst |=> phone_mute && mic_mute && !mic_boost_enable
			&& phone_single_input_gain == 5'h08
			&& mic_single_input_gain == 5'h08)
		else $error("phone or mic not at default after reset");

	a_rst_stereo: assert property (@(posedge clk) // RQ19
		rst |=> line_mute && cd_mute && video_mute
			&& line_left_input_gain == 5'h08 && line_right_input_gain == 5'h08
			&& cd_left_input_gain == 5'h08 && cd_right_input_gain == 5'h08
			&& video_left_input_gain == 5'h08 && video_right_input_gain == 5'h08)
		else $error("stereo inputs not at default after reset");

	a_rst_level: assert property (@(posedge clk) // RQ5
		rst |=> !line_level_select)
		else $error("line level select not cleared by reset");

	a_default_rest: assert property (@(posedge clk) disable iff (rst) // RQ17
		s_reset_write |=> master_right_out_atten == 5'h00 && alt_left_out_atten == 5'h00
			&& alt_right_out_atten == 5'h00 && mono_out_atten == 5'h00)
		else $error("output attenuation not back to default");

	a_default_rest_in: assert property (@(posedge clk) disable iff (rst) // RQ19
		s_reset_write |=> mic_mute && line_mute && cd_mute
			&& line_right_input_gain == 5'h08 && cd_left_input_gain == 5'h08
			&& video_right_input_gain == 5'h08)
		else $error("input gains not back to default");

	a_stereo_reserved: assert property (@(posedge clk) disable iff (rst) // RQ22
		s_stereo_read |=> (rdata & ~mixer_regs_pkg::MASK_STEREO) == 16'h0000)
		else $error("reserved stereo register bits read back");

	a_odd_write_kept: assert property (@(posedge clk) disable iff (rst) // RQ20
		s_odd_write |=> $stable(master_mute) && $stable(master_left_out_atten)
			&& $stable(master_right_out_atten))
		else $error("odd index write reached a register");

endmodule // audio_mixer_volume_regs

// file: pkg/mixer_regs_pkg.sv
/*
 mixer control register bank: indexes, field positions, reset values, write masks.
 assumes a 7-bit register index and 16-bit register words on a plain port.
*/
package mixer_regs_pkg;

	localparam int          ADDR_W    = 7;
	localparam int          DATA_W    = 16;
	localparam int          NUM_VOL   = 9;

	localparam logic [6:0]  IDX_RESET     = 7'h00;
	localparam logic [6:0]  IDX_MASTER    = 7'h02;
	localparam logic [6:0]  IDX_ALT_LINE  = 7'h04;
	localparam logic [6:0]  IDX_MONO      = 7'h06;
	localparam logic [6:0]  IDX_BEEP      = 7'h0a;
	localparam logic [6:0]  IDX_PHONE     = 7'h0c;
	localparam logic [6:0]  IDX_MIC       = 7'h0e;
	localparam logic [6:0]  IDX_LINE_IN   = 7'h10;
	localparam logic [6:0]  IDX_CD        = 7'h12;
	localparam logic [6:0]  IDX_VIDEO     = 7'h14;
	localparam logic [6:0]  IDX_TEST_CTRL = 7'h5a;

	// slot numbers in the volume array
	localparam int          SLOT_MASTER = 0;
	localparam int          SLOT_ALT    = 1;
	localparam int          SLOT_MONO   = 2;
	localparam int          SLOT_BEEP   = 3;
	localparam int          SLOT_PHONE  = 4;
	localparam int          SLOT_MIC    = 5;
	localparam int          SLOT_LINE   = 6;
	localparam int          SLOT_CD     = 7;
	localparam int          SLOT_VIDEO  = 8;

	// field positions
	localparam int          MUTE_BIT      = 15;
	localparam int          LEFT_LSB      = 8;
	localparam int          RIGHT_LSB     = 0;
	localparam int          BEEP_LSB      = 1;
	localparam int          BOOST_BIT     = 6;
	localparam int          LVL_BIT       = 15;
	localparam int          ENH_LSB       = 10;
	localparam int          ADC20_BIT     = 8;
	localparam int          DAC20_BIT     = 6;
	localparam int          ALT_LINE_BIT  = 4;

	// reset values
	localparam logic [15:0] RST_OUT    = 16'h8000;
	localparam logic [15:0] RST_MONO   = 16'h8008;
	localparam logic [15:0] RST_STEREO = 16'h8808;
	localparam logic        RST_LVL    = 1'b0;

	// writable bits per register
	localparam logic [15:0] MASK_STEREO = 16'h9f1f;
	localparam logic [15:0] MASK_MONO   = 16'h801f;
	localparam logic [15:0] MASK_BEEP   = 16'h801e;
	localparam logic [15:0] MASK_MIC    = 16'h805f;

	localparam logic [6:0]  VOL_INDEX [NUM_VOL] = '{IDX_MASTER, IDX_ALT_LINE, IDX_MONO,
		IDX_BEEP, IDX_PHONE, IDX_MIC, IDX_LINE_IN, IDX_CD, IDX_VIDEO};
	localparam logic [15:0] VOL_RESET [NUM_VOL] = '{RST_OUT, RST_OUT, RST_OUT, RST_OUT,
		RST_MONO, RST_MONO, RST_STEREO, RST_STEREO, RST_STEREO};
	localparam logic [15:0] VOL_MASK  [NUM_VOL] = '{MASK_STEREO, MASK_STEREO, MASK_MONO,
		MASK_BEEP, MASK_MONO, MASK_MIC, MASK_STEREO, MASK_STEREO, MASK_STEREO};

	// enhancement technique code, value arbitrary
	localparam logic [4:0]  ENH_CODE_DEFAULT = 5'h05;

endpackage

// file: testbench/mixer_ctl_model.sv
/*
 audio controller model: drives one-cycle register writes and reads.
 assumes read data stand in the cycle after the read strobe.
*/
`timescale 1ns/100ps
module mixer_ctl_model (
	input  wire logic        clk,
	output logic      [6:0]  addr,
	output logic      [15:0] wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [15:0] rdata
);
	initial begin
		addr = 7'h7f;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end

	task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// released bus shows no stale data
		wdata <= ~d;
	endtask

	task automatic rd_reg(input logic [6:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
endmodule // mixer_ctl_model

// file: testbench/tb_audio_mixer_volume_regs.sv
/*
 self-checking bench for the mixer volume register bank.
 assumes the register package and the controller model are compiled first.
*/
`timescale 1ns/100ps
module tb_audio_mixer_volume_regs;
	typedef struct packed {
		logic [6:0]  a;
		logic [15:0] d;
		logic [15:0] e;
	} row_s;
	localparam logic [4:0] ENH = 5'h0b; // arbitrary value
	// line select written first, before the alternate line is used
	localparam row_s ROWS [12] = '{
		'{7'h5a, 16'hffff, 16'h8000}, '{7'h02, 16'hffff, 16'h9f1f}, '{7'h04, 16'h6a15, 16'h0a15},
		'{7'h06, 16'hffff, 16'h801f}, '{7'h0a, 16'hffff, 16'h801e}, '{7'h0c, 16'h7fe3, 16'h0003},
		'{7'h0e, 16'hffff, 16'h805f}, '{7'h10, 16'h1208, 16'h1208}, '{7'h12, 16'he0ff, 16'h801f},
		'{7'h14, 16'h1f00, 16'h1f00}, '{7'h03, 16'h0000, 16'h0000}, '{7'h16, 16'hffff, 16'h0000}};
	logic        clk;
	logic        rst;
	logic [6:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        master_mute;
	logic [4:0]  master_left_out_atten;
	logic [4:0]  alt_right_out_atten;
	logic        line_level_select;
	logic [3:0]  beep_atten;
	logic        beep_input_bypass;
	logic        mic_boost_enable;
	logic        line_mute;
	logic [4:0]  video_left_input_gain;
	logic [15:0] v;
	int          error_cnt = 0;
	int          checked = 0;
	int          cycles = 0;

	audio_mixer_volume_regs #(.ENH_CODE(ENH)) dut_u (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .master_mute(master_mute),
		.master_left_out_atten(master_left_out_atten), .master_right_out_atten(),
		.alt_mute(), .alt_left_out_atten(), .alt_right_out_atten(alt_right_out_atten),
		.line_level_select(line_level_select), .mono_mute(), .mono_out_atten(),
		.beep_mute(), .beep_atten(beep_atten), .beep_input_bypass(beep_input_bypass),
		.phone_mute(), .phone_single_input_gain(), .mic_mute(), .mic_single_input_gain(),
		.mic_boost_enable(mic_boost_enable), .line_mute(line_mute), .line_left_input_gain(),
		.line_right_input_gain(), .cd_mute(), .cd_left_input_gain(), .cd_right_input_gain(),
		.video_mute(), .video_left_input_gain(video_left_input_gain), .video_right_input_gain());

	mixer_ctl_model ctl_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_defaults;
		logic [15:0] r;
		for (int i = 0; i < mixer_regs_pkg::NUM_VOL; i++) begin
			ctl_u.rd_reg(mixer_regs_pkg::VOL_INDEX[i], r);
			chk(r, mixer_regs_pkg::VOL_RESET[i]);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			$display("ERROR %0t run did not finish", $time);
			tally_and_finish();
		end
	end

	initial begin
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(16'(beep_input_bypass), 16'h0001);
		@(posedge clk);
		#1;
		chk(16'(beep_input_bypass), 16'h0000);
		chk_defaults();
		$display("reset defaults test done");
		foreach (ROWS[i]) begin
			ctl_u.wr_reg(ROWS[i].a, ROWS[i].d);
			ctl_u.rd_reg(ROWS[i].a, v);
			chk(v, ROWS[i].e);
		end
		chk(16'(master_left_out_atten), 16'h001f);
		chk(16'(alt_right_out_atten), 16'h0015);
		chk(16'(beep_atten), 16'h000f);
		chk(16'(mic_boost_enable), 16'h0001);
		chk(16'(line_mute), 16'h0000);
		chk(16'(video_left_input_gain), 16'h001f);
		chk(16'(line_level_select), 16'h0001);
		$display("register rows test done");
		ctl_u.rd_reg(mixer_regs_pkg::IDX_RESET, v);
		chk(v, {1'b0, ENH, 10'h150});
		ctl_u.wr_reg(mixer_regs_pkg::IDX_RESET, 16'hffff);
		ctl_u.rd_reg(mixer_regs_pkg::IDX_RESET, v);
		chk(v, {1'b0, ENH, 10'h150});
		chk_defaults();
		chk(16'(line_level_select), 16'h0001);
		$display("reset register test done");
		ctl_u.wr_reg(mixer_regs_pkg::IDX_MASTER, 16'h0000);
		@(posedge clk);
		rst <= 1'b1;
		#1;
		chk(16'(master_mute), 16'h0000);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(16'(beep_input_bypass), 16'h0001);
		chk(16'(master_mute), 16'h0001);
		chk(16'(line_level_select), 16'h0000);
		@(posedge clk);
		#1;
		chk(16'(beep_input_bypass), 16'h0000);
		chk_defaults();
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule // tb_audio_mixer_volume_regs
